// ### hdl/qdtm_pkg.sv
package qdtm_pkg;
   localparam int NUM_CH = 4;
   localparam int CODE_W = 14;
   localparam int FRAC_W = 5;
   localparam int OUT_W  = CODE_W + FRAC_W;
   localparam int CALC_W = 24;

   // Register group numbers in address bits 7:4, channel n at base + 4*n
   localparam logic [3:0] GRP_MONITOR = 4'h0;
   localparam logic [3:0] GRP_CODE    = 4'h1;
   localparam logic [3:0] GRP_OFFSET  = 4'h2;
   localparam logic [3:0] GRP_SLOPE   = 4'h3;
   localparam logic [3:0] GRP_LATCH   = 4'h4;
   localparam logic [3:0] GRP_TRIMMED = 4'h5;
   localparam logic [1:0] SUB_MONITOR = 2'h0;
   localparam logic [1:0] SUB_CONFIG  = 2'h1;
   localparam logic [1:0] SUB_LOAD    = 2'h2;

   // Writable bit masks; zeros are reserved and read back as zero
   localparam logic [15:0] MON_MASK    = 16'hf800;
   localparam logic [15:0] CODE_MASK   = 16'hfffc;
   localparam logic [15:0] OFFSET_MASK = 16'h01ff;
   localparam logic [15:0] SLOPE_MASK  = 16'h00ff;
   localparam logic [15:0] CONFIG_MASK = 16'h00ff;
   localparam logic [15:0] LOAD_MASK   = 16'h001f;

   localparam logic [15:0] REG_RESET    = 16'h0000;
   localparam logic [15:0] CONFIG_RESET = 16'h000f;

   localparam int MON_SEL_LSB   = 11;
   localparam int MON_SEL_W     = 5;
   localparam int CODE_LSB      = 2;
   localparam int CFG_GAIN_LSB  = 0;
   localparam int CFG_UNI_LSB   = 4;
   localparam int LOAD_CLR_BIT  = 4;

   localparam int SLOPE_SHIFT_BIP = 10;
   localparam int SLOPE_SHIFT_UNI = 11;

   localparam logic signed [CALC_W-1:0] BIP_MIN = -24'sd262144;
   localparam logic signed [CALC_W-1:0] BIP_MAX = 24'sd262143;
   localparam logic signed [CALC_W-1:0] UNI_MIN = 24'sd0;
   localparam logic signed [CALC_W-1:0] UNI_MAX = 24'sd524287;

   function automatic logic [15:0] qdtm_merge(input logic [15:0] old_v,
                                              input logic [15:0] new_v,
                                              input logic [1:0]  sel,
                                              input logic [15:0] mask);
      logic [15:0] lanes;
      lanes = {{8{sel[1]}}, {8{sel[0]}}};
      qdtm_merge = ((old_v & ~lanes) | (new_v & lanes)) & mask;
   endfunction

   function automatic logic signed [CALC_W-1:0] qdtm_clip(
         input logic signed [CALC_W-1:0] v,
         input logic signed [CALC_W-1:0] lo,
         input logic signed [CALC_W-1:0] hi);
      if (v < lo) begin
         qdtm_clip = lo;
      end else if (v > hi) begin
         qdtm_clip = hi;
      end else begin
         qdtm_clip = v;
      end
   endfunction
endpackage

// ### hdl/qdtm_trim.sv
module qdtm_trim (
   input  wire logic                          clk_in,
   input  wire logic                          rst_n_in,
   input  wire logic [qdtm_pkg::CODE_W-1:0]   latch_code_in,
   input  wire logic [8:0]                    offset_trim_value_in,
   input  wire logic [7:0]                    slope_trim_value_in,
   input  wire logic                          unipolar_in,
   output logic      [qdtm_pkg::OUT_W-1:0]    trimmed_code_out
);
   import qdtm_pkg::*;

   logic signed [CALC_W-1:0] base;
   logic signed [CALC_W-1:0] slope;
   logic signed [CALC_W-1:0] offs;
   logic signed [CALC_W-1:0] prod;
   logic signed [CALC_W-1:0] slope_adj;
   logic signed [CALC_W-1:0] sum;
   logic signed [CALC_W-1:0] clipped;

   always_comb begin
      if (unipolar_in) begin
         base = {10'h000, latch_code_in};
      end else begin
         base = {{10{latch_code_in[CODE_W-1]}}, latch_code_in};
      end
   end

   assign offs  = {{15{offset_trim_value_in[8]}}, offset_trim_value_in};
   assign slope = {{16{slope_trim_value_in[7]}}, slope_trim_value_in};
   assign prod  = base * slope;

   always_comb begin
      if (unipolar_in) begin
         slope_adj = prod >>> SLOPE_SHIFT_UNI;
      end else begin
         slope_adj = prod >>> SLOPE_SHIFT_BIP;
      end
   end

   assign sum = (base <<< FRAC_W) + slope_adj + offs;

   always_comb begin
      if (unipolar_in) begin
         clipped = qdtm_clip(sum, UNI_MIN, UNI_MAX);
      end else begin
         clipped = qdtm_clip(sum, BIP_MIN, BIP_MAX);
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         trimmed_code_out <= '0;
      end else begin
         trimmed_code_out <= clipped[OUT_W-1:0];
      end
   end
endmodule // qdtm_trim

// ### hdl/qdtm_monitor.sv
module qdtm_monitor (
   input  wire logic                           clk_in,
   input  wire logic                           rst_n_in,
   input  wire logic [qdtm_pkg::MON_SEL_W-1:0] select_in,
   output logic      [qdtm_pkg::MON_SEL_W-1:0] monitor_route_out,
   output logic                                monitor_oe_n_out
);
   import qdtm_pkg::*;

   logic one_hot;

   // Several bits set is illegal; the pin is released rather than shorted
   assign one_hot = (select_in != '0) &&
                    ((select_in & (select_in - 5'h01)) == '0);

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         monitor_route_out <= '0;
         monitor_oe_n_out  <= 1'b1;
      end else begin
         monitor_route_out <= one_hot ? select_in : '0;
         monitor_oe_n_out  <= ~one_hot;
      end
   end
endmodule // qdtm_monitor

// ### hdl/qdtm_core.sv
// Function
// - Monitor bit 11 picks aux input, bits 12 to 15 pick channels 0-3.
// - All monitor bits zero disables monitor, output high impedance.
// - Reset clears the monitor selector, monitor starts disabled.
// - Reserved bits ignore writes and read back zero.
// - Channel code sits in bits 15..2, bits 1..0 reserved.
// - Code registers reset to zero and keep the last write until a load register write with bit 4 set clears them.
// - Output follows a new code only after transfer into the latch.
// - Code is two's complement in bipolar, straight binary in unipolar.
// - Bipolar output is half gain times reference times code over 8192.
// - Unipolar output is gain times reference times code over 16384.
// - Offset trim is 9 bits, bits 15..9 reserved, 1/32 step each.
// - Offset trim is signed in both modes, zero means no change.
// - Slope trim is 8 bits, bits 15..8 reserved, quarter step each.
// - Slope trim signed in both modes, resets to zero.
// - Trims are per channel and affect only that channel.
// - Offset shifts transfer function, slope trim turns it about zero.
// - Gain bit set selects gain four, clear selects gain two.
//
// Chosen here: the placing of the registers and the Wishbone interface to the registers.
module qdtm_core (
   input  wire logic                        clk_in,
   input  wire logic                        rst_n_in,
   input  wire logic                        wb_cyc_in,
   input  wire logic                        wb_stb_in,
   input  wire logic                        wb_we_in,
   input  wire logic [7:0]                  wb_adr_in,
   input  wire logic [3:0]                  wb_sel_in,
   input  wire logic [31:0]                 wb_dat_in,
   output logic      [31:0]                 wb_dat_out,
   output logic                             wb_ack_out,
   input  wire logic                        latch_load_in,
   output logic      [qdtm_pkg::OUT_W-1:0]  trimmed_code0_out,
   output logic      [qdtm_pkg::OUT_W-1:0]  trimmed_code1_out,
   output logic      [qdtm_pkg::OUT_W-1:0]  trimmed_code2_out,
   output logic      [qdtm_pkg::OUT_W-1:0]  trimmed_code3_out,
   output logic      [qdtm_pkg::NUM_CH-1:0] gain_x4_out,
   output logic      [qdtm_pkg::NUM_CH-1:0] unipolar_out,
   output logic      [4:0]                  monitor_route_out,
   output logic                             monitor_oe_n_out
);
   import qdtm_pkg::*;

   logic [15:0]          monitor_select_r;
   logic [15:0]          config_r;
   logic [15:0]          channel_input_code_r  [NUM_CH];
   logic [15:0]          channel_offset_trim_r [NUM_CH];
   logic [15:0]          channel_slope_trim_r  [NUM_CH];
   logic [CODE_W-1:0]    latch_r               [NUM_CH];
   logic [OUT_W-1:0]     trimmed               [NUM_CH];
   logic                 ack_r;
   logic [31:0]          rdata_r;
   logic [31:0]          rdata_nxt;
   logic                 access;
   logic                 wr;
   logic [3:0]           grp;
   logic [1:0]           sub;
   logic [15:0]          wdat;
   logic [1:0]           wsel;
   logic                 load_wr;
   logic                 clear_req;
   logic [NUM_CH-1:0]    load_mask;

   // Answer once per request; no request is taken in the ack cycle, so a
   // strobe still held there is not taken twice
   assign access = wb_cyc_in && wb_stb_in && !ack_r;
   assign wr     = access && wb_we_in;
   assign grp    = wb_adr_in[7:4];
   assign sub    = wb_adr_in[3:2];
   assign wdat   = wb_dat_in[15:0];
   assign wsel   = wb_sel_in[1:0];

   assign load_wr   = wr && (grp == GRP_MONITOR) && (sub == SUB_LOAD);
   assign clear_req = load_wr && wsel[0] && wdat[LOAD_CLR_BIT];

   // transfer by pin or load register
   always_comb begin
      load_mask = '0;
      if (latch_load_in) begin
         load_mask = '1;
      end
      if (load_wr && wsel[0]) begin
         load_mask = load_mask | wdat[NUM_CH-1:0];
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= access;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         monitor_select_r <= REG_RESET;
      end else if (clear_req) begin
         monitor_select_r <= REG_RESET;
      end else if (wr && grp == GRP_MONITOR && sub == SUB_MONITOR) begin
         monitor_select_r <= qdtm_merge(monitor_select_r, wdat, wsel,
                                        MON_MASK);
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         config_r <= CONFIG_RESET;
      end else if (clear_req) begin
         config_r <= CONFIG_RESET;
      end else if (wr && grp == GRP_MONITOR && sub == SUB_CONFIG) begin
         config_r <= qdtm_merge(config_r, wdat, wsel, CONFIG_MASK);
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < NUM_CH; i++) begin
            channel_input_code_r[i]  <= REG_RESET;
            channel_offset_trim_r[i] <= REG_RESET;
            channel_slope_trim_r[i]  <= REG_RESET;
         end
      end else if (clear_req) begin
         for (int i = 0; i < NUM_CH; i++) begin
            channel_input_code_r[i]  <= REG_RESET;
            channel_offset_trim_r[i] <= REG_RESET;
            channel_slope_trim_r[i]  <= REG_RESET;
         end
      end else if (wr) begin
         unique case (grp)
            GRP_CODE: begin
               channel_input_code_r[sub] <=
                  qdtm_merge(channel_input_code_r[sub], wdat, wsel,
                             CODE_MASK);
            end
            GRP_OFFSET: begin
               channel_offset_trim_r[sub] <=
                  qdtm_merge(channel_offset_trim_r[sub], wdat, wsel,
                             OFFSET_MASK);
            end
            GRP_SLOPE: begin
               channel_slope_trim_r[sub] <=
                  qdtm_merge(channel_slope_trim_r[sub], wdat, wsel,
                             SLOPE_MASK);
            end
            default: begin
            end
         endcase
      end
   end

   // Latches hold the data that sets each output
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < NUM_CH; i++) begin
            latch_r[i] <= '0;
         end
      end else if (clear_req) begin
         for (int i = 0; i < NUM_CH; i++) begin
            latch_r[i] <= '0;
         end
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (load_mask[i]) begin
               latch_r[i] <= channel_input_code_r[i][15:CODE_LSB];
            end
         end
      end
   end

   // Mode pins follow config; gain bit here drives the range switch
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         gain_x4_out  <= CONFIG_RESET[CFG_GAIN_LSB +: NUM_CH];
         unipolar_out <= CONFIG_RESET[CFG_UNI_LSB +: NUM_CH];
      end else begin
         gain_x4_out  <= config_r[CFG_GAIN_LSB +: NUM_CH];
         unipolar_out <= config_r[CFG_UNI_LSB +: NUM_CH];
      end
   end

   // Readback; unmapped offsets answer with zero
   always_comb begin
      rdata_nxt = '0;
      unique case (grp)
         GRP_MONITOR: begin
            if (sub == SUB_MONITOR) begin
               rdata_nxt[15:0] = monitor_select_r;
            end else if (sub == SUB_CONFIG) begin
               rdata_nxt[15:0] = config_r;
            end
         end
         GRP_CODE: begin
            rdata_nxt[15:0] = channel_input_code_r[sub];
         end
         GRP_OFFSET: begin
            rdata_nxt[15:0] = channel_offset_trim_r[sub];
         end
         GRP_SLOPE: begin
            rdata_nxt[15:0] = channel_slope_trim_r[sub];
         end
         GRP_LATCH: begin
            rdata_nxt[15:CODE_LSB] = latch_r[sub];
         end
         GRP_TRIMMED: begin
            rdata_nxt[OUT_W-1:0] = trimmed[sub];
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_r <= '0;
      end else if (access && !wb_we_in) begin
         rdata_r <= rdata_nxt;
      end
   end

   assign wb_ack_out = ack_r;
   assign wb_dat_out = rdata_r;

   for (genvar g = 0; g < NUM_CH; g++) begin : g_trim
      qdtm_trim u_trim (
         .clk_in               (clk_in),
         .rst_n_in             (rst_n_in),
         .latch_code_in        (latch_r[g]),
         .offset_trim_value_in (channel_offset_trim_r[g][8:0]),
         .slope_trim_value_in  (channel_slope_trim_r[g][7:0]),
         .unipolar_in          (config_r[CFG_UNI_LSB + g]),
         .trimmed_code_out     (trimmed[g])
      );
   end

   assign trimmed_code0_out = trimmed[0];
   assign trimmed_code1_out = trimmed[1];
   assign trimmed_code2_out = trimmed[2];
   assign trimmed_code3_out = trimmed[3];

   qdtm_monitor u_monitor (
      .clk_in            (clk_in),
      .rst_n_in          (rst_n_in),
      .select_in         (monitor_select_r[MON_SEL_LSB +: MON_SEL_W]),
      .monitor_route_out (monitor_route_out),
      .monitor_oe_n_out  (monitor_oe_n_out)
   );
endmodule // qdtm_core

// ### test/qdtm_core_properties.sv
module qdtm_core_properties (
   input wire logic                        clk_in,
   input wire logic                        rst_n_in,
   input wire logic                        wb_cyc_in,
   input wire logic                        wb_stb_in,
   input wire logic                        wb_we_in,
   input wire logic [7:0]                  wb_adr_in,
   input wire logic [3:0]                  wb_sel_in,
   input wire logic [31:0]                 wb_dat_in,
   input wire logic [31:0]                 wb_dat_out,
   input wire logic                        wb_ack_out,
   input wire logic                        latch_load_in,
   input wire logic [qdtm_pkg::OUT_W-1:0]  trimmed_code0_out,
   input wire logic [qdtm_pkg::OUT_W-1:0]  trimmed_code1_out,
   input wire logic [qdtm_pkg::OUT_W-1:0]  trimmed_code2_out,
   input wire logic [qdtm_pkg::OUT_W-1:0]  trimmed_code3_out,
   input wire logic [qdtm_pkg::NUM_CH-1:0] gain_x4_out,
   input wire logic [qdtm_pkg::NUM_CH-1:0] unipolar_out,
   input wire logic [4:0]                  monitor_route_out,
   input wire logic                        monitor_oe_n_out
);
   import qdtm_pkg::*;
   logic        take;
   logic        quiet;
   logic [15:0] cap_r;
   assign take  = wb_cyc_in && wb_stb_in && !wb_ack_out;
   assign quiet = !latch_load_in && !(wb_cyc_in && wb_stb_in && wb_we_in);
   // Write data is held only until ack, so keep a copy
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cap_r <= 16'h0000;
      end else if (take) begin
         cap_r <= wb_dat_in[15:0];
      end
   end
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);
   property p_ack_resp;
      take |=> wb_ack_out;
   endproperty
   a_ack_resp: assert property (p_ack_resp)
      else $error("request not acknowledged");
   property p_ack_pulse;
      wb_ack_out |=> !wb_ack_out;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack longer than one cycle");
   property p_mon_hiz;
      monitor_oe_n_out == (monitor_route_out == 5'h00);
   endproperty
   a_mon_hiz: assert property (p_mon_hiz)
      else $error("monitor enable disagrees with route");
   property p_mon_onehot;
      $countones(monitor_route_out) <= 1;
   endproperty
   a_mon_onehot: assert property (p_mon_onehot)
      else $error("monitor routes more than one source");
   property p_mon_write;
      take && wb_we_in && wb_adr_in == 8'h00 && wb_sel_in[1] |=> ##[0:1]
         monitor_route_out ==
         (($countones(cap_r[15:11]) > 1) ? 5'h00 : cap_r[15:11]);
   endproperty
   a_mon_write: assert property (p_mon_write)
      else $error("monitor route does not follow selector");
   property p_rsv_upper;
      wb_ack_out |-> wb_dat_out[31:16] == 16'h0000;
   endproperty
   a_rsv_upper: assert property (p_rsv_upper)
      else $error("unused read bits not zero");
   property p_trim_hold;
      quiet [*2] |=> $stable(trimmed_code0_out) && $stable(trimmed_code1_out)
         && $stable(trimmed_code2_out) && $stable(trimmed_code3_out);
   endproperty
   a_trim_hold: assert property (p_trim_hold)
      else $error("output code moved without load");
   property p_cfg;
      take && wb_we_in && wb_adr_in == 8'h04 && wb_sel_in[0] |=> ##[0:1]
         {unipolar_out, gain_x4_out} == cap_r[7:0];
   endproperty
   a_cfg: assert property (p_cfg)
      else $error("gain or mode outputs do not follow config");
   c_mon_on: cover property (!monitor_oe_n_out);
   c_pin_load: cover property (latch_load_in && quiet == 1'b0);
   c_clear: cover property (take && wb_we_in && wb_adr_in == 8'h08
      && wb_dat_in[4]);
endmodule // qdtm_core_properties

bind qdtm_core qdtm_core_properties u_qdtm_core_properties (
   .clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in),
   .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
   .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
   .wb_ack_out(wb_ack_out), .latch_load_in(latch_load_in),
   .trimmed_code0_out(trimmed_code0_out),
   .trimmed_code1_out(trimmed_code1_out),
   .trimmed_code2_out(trimmed_code2_out),
   .trimmed_code3_out(trimmed_code3_out), .gain_x4_out(gain_x4_out),
   .unipolar_out(unipolar_out), .monitor_route_out(monitor_route_out),
   .monitor_oe_n_out(monitor_oe_n_out));

// ### test/qdtm_host_model.sv
module qdtm_host_model (
   input  wire logic        clk_in,
   input  wire logic        ack_in,
   input  wire logic [31:0] rdat_in,
   output logic             cyc_out,
   output logic             stb_out,
   output logic             we_out,
   output logic [7:0]       adr_out,
   output logic [3:0]       sel_out,
   output logic [31:0]      wdat_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cyc_out = 1'b0;
      stb_out = 1'b0;
      we_out = 1'b0;
      adr_out = 8'h00;
      sel_out = 4'h0;
      wdat_out = 32'h0000_0000;
   end
   function automatic logic [15:0] cal_steps(input real err, input real st);
      cal_steps = 16'(int'(-err / st));
   endfunction
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [1:0] s, input logic [15:0] d,
                       output logic [15:0] r, output bit ok);
      int n;
      n = 0;
      cyc_out <= 1'b1;
      stb_out <= 1'b1;
      we_out <= w;
      adr_out <= a;
      sel_out <= {2'b00, s};
      wdat_out <= {16'h0000, d};
      do begin
         @(posedge clk_in);
         n++;
      end while (ack_in !== 1'b1 && n < 64);
      r = rdat_in[15:0];
      ok = (ack_in === 1'b1);
      cyc_out <= 1'b0;
      stb_out <= 1'b0;
      // Released lines must not keep looking valid
      adr_out <= ~a;
      wdat_out <= ~wdat_out;
      @(posedge clk_in);
   endtask
endmodule // qdtm_host_model

// ### test/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import qdtm_pkg::*;
   logic             clk_in = 1'b0;
   logic             rst_n_in = 1'b0;
   logic             latch_load_in = 1'b0;
   logic             cyc, stb, we, ack, oe_n;
   logic [7:0]       adr;
   logic [3:0]       sel, gx4, uni;
   logic [31:0]      wdat, rdat;
   logic [4:0]       route;
   logic [OUT_W-1:0] tc [NUM_CH];
   logic [15:0]      lfsr = 16'h0023;
   logic [15:0]      m_code [4], m_off [4], m_slp [4], m_lat [4];
   logic [15:0]      m_mon, m_cfg;
   logic [15:0]      bcode [4] = '{16'h7fff, 16'h8000, 16'hffff, 16'h0003};
   int               num_errors = 0;
   int               tests_run = 0;
   always #4 clk_in = ~clk_in;
   qdtm_host_model u_qdtm_host_model (.clk_in(clk_in), .ack_in(ack),
      .rdat_in(rdat), .cyc_out(cyc), .stb_out(stb), .we_out(we),
      .adr_out(adr), .sel_out(sel), .wdat_out(wdat));
   qdtm_core u_qdtm_core (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
      .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
      .wb_ack_out(ack), .latch_load_in(latch_load_in),
      .trimmed_code0_out(tc[0]), .trimmed_code1_out(tc[1]),
      .trimmed_code2_out(tc[2]), .trimmed_code3_out(tc[3]),
      .gain_x4_out(gx4), .unipolar_out(uni), .monitor_route_out(route),
      .monitor_oe_n_out(oe_n));
   function automatic logic [15:0] nxt(input logic [15:0] s);
      nxt = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [15:0] mrg(input logic [15:0] o, d,
                                       input logic [1:0] s,
                                       input logic [15:0] m);
      logic [15:0] l;
      l = {{8{s[1]}}, {8{s[0]}}};
      mrg = ((o & ~l) | (d & l)) & m;
   endfunction
   function automatic logic [15:0] m_rd(input logic [7:0] a);
      case (a[7:4])
         4'h0: m_rd = a[3] ? 16'h0000 : a[2] ? m_cfg : m_mon;
         4'h1: m_rd = m_code[a[3:2]];
         4'h2: m_rd = m_off[a[3:2]];
         4'h3: m_rd = m_slp[a[3:2]];
         4'h4: m_rd = m_lat[a[3:2]];
         default: m_rd = 16'h0000;
      endcase
   endfunction
   // Units of 1/32 step, clipped rather than wrapped
   function automatic logic [18:0] m_trim(input int n);
      int b, v, s;
      b = m_cfg[4+n] ? int'(m_lat[n][15:2]) : int'($signed(m_lat[n][15:2]));
      s = m_cfg[4+n] ? 11 : 10;
      v = b * 32 + ((b * int'($signed(m_slp[n][7:0]))) >>> s)
          + int'($signed(m_off[n][8:0]));
      if (m_cfg[4+n]) v = (v < 0) ? 0 : (v > 524287) ? 524287 : v;
      else v = (v < -262144) ? -262144 : (v > 262143) ? 262143 : v;
      m_trim = v[18:0];
   endfunction
   task automatic final_report();
      $display("checks=%0d errors=%0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic ld(input logic [4:0] m);
      for (int n = 0; n < 4; n++) begin
         if (m[4]) begin
            m_code[n] = 16'h0000;
            m_off[n] = 16'h0000;
            m_slp[n] = 16'h0000;
            m_lat[n] = 16'h0000;
         end else if (m[n]) m_lat[n] = m_code[n];
      end
      if (m[4]) m_mon = 16'h0000;
      if (m[4]) m_cfg = 16'h000f;
   endtask
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [15:0] d, input logic [1:0] s,
                       output logic [15:0] r);
      bit ok;
      u_qdtm_host_model.xfer(w, a, s, d, r, ok);
      if (!ok) begin
         num_errors++;
         final_report();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d,
                     input logic [1:0] s = 2'b11);
      logic [15:0] r;
      xfer(1'b1, a, d, s, r);
      if (a == 8'h00) m_mon = mrg(m_mon, d, s, 16'hf800);
      if (a == 8'h04) m_cfg = mrg(m_cfg, d, s, 16'h00ff);
      if (a == 8'h08 && s[0]) ld(d[4:0]);
      if (a[7:4] == 4'h1) m_code[a[3:2]] = mrg(m_code[a[3:2]], d, s, 16'hfffc);
      if (a[7:4] == 4'h2) m_off[a[3:2]] = mrg(m_off[a[3:2]], d, s, 16'h01ff);
      if (a[7:4] == 4'h3) m_slp[a[3:2]] = mrg(m_slp[a[3:2]], d, s, 16'h00ff);
   endtask
   task automatic rd(input logic [7:0] a);
      logic [15:0] r;
      xfer(1'b0, a, 16'h0000, 2'b11, r);
      check({16'h0000, r}, {16'h0000, m_rd(a)});
   endtask
   task automatic settle();
      repeat (3) @(posedge clk_in);
      @(negedge clk_in);
      for (int n = 0; n < 4; n++) check(32'(tc[n]), 32'(m_trim(n)));
      check(32'({oe_n, route, uni, gx4}),
            32'({m_mon == 16'h0000, m_mon[15:11], m_cfg[7:0]}));
      @(posedge clk_in);
   endtask
   task automatic rd_all();
      for (int a = 0; a < 'h50; a += 4) rd(8'(a));
   endtask
   initial begin
      logic [15:0] t;
      int n;
      ld(5'h10);
      repeat (16) @(posedge clk_in);
      rst_n_in <= 1'b1;
      @(posedge clk_in);
      rd_all();
      settle();
      for (int i = 0; i < 5; i++) begin
         wr(8'h00, 16'h07ff | (16'h0800 << i));
         rd(8'h00);
         settle();
      end
      wr(8'h00, 16'h0000);
      settle();
      t = u_qdtm_host_model.cal_steps(-1.0e-3, 38.0e-6);
      wr(8'h20, t);
      t = u_qdtm_host_model.cal_steps(-10.0e-3, 305.0e-6);
      wr(8'h30, t);
      wr(8'h08, 16'h0001);
      settle();
      for (int it = 0; it < 32; it++) begin
         n = it % 4;
         lfsr = nxt(lfsr);
         wr(8'h04, (it < 4) ? {8'h00, {4{it[1]}}, 4'ha} : lfsr);
         lfsr = nxt(lfsr);
         wr(8'h10 + 8'(4 * n), (it < 4) ? bcode[it] : lfsr);
         lfsr = nxt(lfsr);
         wr(8'h20 + 8'(4 * n), (it < 4) ? 16'h00ff + it[0] : lfsr);
         lfsr = nxt(lfsr);
         wr(8'h30 + 8'(4 * n), (it < 4) ? 16'h007f + it[0] : lfsr);
         settle();
         if (it[2]) begin
            latch_load_in <= 1'b1;
            @(posedge clk_in);
            latch_load_in <= 1'b0;
            ld(5'h0f);
         end else begin
            wr(8'h08, 16'h0001 << n);
         end
         settle();
         rd(8'h10 + 8'(4 * n));
         rd(8'h40 + 8'(4 * n));
      end
      wr(8'h10, 16'hffff, 2'b01);
      rd(8'h10);
      wr(8'h0c, 16'hffff);
      wr(8'h60, 16'hffff);
      rd(8'h0c);
      rd(8'h60);
      wr(8'h08, 16'h0010);
      settle();
      rd_all();
      final_report();
   end
endmodule // tb
